//--- rtl/dcwf_pkg.sv
// Constants and types shared by the dual-clock wide FIFO design files.
// Assumes nothing of its surroundings.
`default_nettype none
package dcwf_pkg;
	// ==============================================
	// Array geometry
	localparam int               AW       = 10;
	localparam int               DW       = 36;
	localparam int               DEPTH    = 1024;
	localparam logic [AW:0]      FULL_LVL = 11'h400;
	localparam logic [AW:0]      HALF_LVL = 11'h200;
	// ==============================================
	// Reset values
	localparam logic [AW-1:0]    NEAR_DEF  = 10'h008;
	localparam logic [AW-1:0]    RWOFS_RST = 10'h000;
	localparam int               CTRL_W    = 7;
	localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
	// ==============================================
	// Control register bit positions
	localparam int               CB_PGEN   = 0;
	localparam int               CB_EVEN   = 1;
	localparam int               CB_BREV   = 2;
	localparam int               CB_HFSRC  = 3;
	localparam int               CB_OEHOLD = 6;
	// ==============================================
	// APB byte offsets
	localparam logic [7:0]       OFS_CTRL   = 8'h00;
	localparam logic [7:0]       OFS_AFULL  = 8'h04;
	localparam logic [7:0]       OFS_AEMPTY = 8'h08;
	localparam logic [7:0]       OFS_RWOFS  = 8'h0C;
	localparam logic [7:0]       OFS_MBOX   = 8'h10;
	localparam logic [7:0]       OFS_STAT   = 8'h14;
	localparam logic [7:0]       OFS_MARK   = 8'h18;
	// ==============================================
	// Encodings
	typedef enum logic [1:0] {
		W36 = 2'b00,
		W18 = 2'b01,
		W9  = 2'b10
	} dcwf_width_t;
	typedef enum logic [1:0] {
		RW_SETMARK = 2'b00,
		RW_TOMARK  = 2'b01,
		RW_MARKOFS = 2'b10,
		RW_SKIP    = 2'b11
	} dcwf_rewind_t;
	typedef enum logic [2:0] {
		PA_NONE   = 3'b000,
		PA_MBOX   = 3'b001,
		PA_CTRL   = 3'b010,
		PA_AFULL  = 3'b011,
		PA_AEMPTY = 3'b100,
		PA_RWOFS  = 3'b101
	} dcwf_paddr_t;
endpackage
`default_nettype wire

//--- rtl/dcwf_sync.sv
// Two-flop synchroniser for a bundle of bits.
// Assumes its input comes from pins or a foreign timing domain.
`default_nettype none
module dcwf_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,   // Sampling clock
	input  wire logic         rst_n, // Async reset, active low
	input  wire logic [W-1:0] din,   // Foreign level
	output logic      [W-1:0] dout   // Synchronised level
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			dout   <= '0;
		end else begin
			meta_r <= din;
			dout   <= meta_r;
		end
	end
endmodule // dcwf_sync
`default_nettype wire

//--- rtl/dcwf_ram.sv
// Simple dual-port array of DEPTH words with registered read data.
// Assumes the caller never reads and writes one address in one cycle.
`default_nettype none
module dcwf_ram
	import dcwf_pkg::*;
(
	input  wire logic          clk,   // Core clock
	input  wire logic          we,    // Write strobe
	input  wire logic [AW-1:0] waddr, // Write address
	input  wire logic [DW-1:0] wdata, // Write word
	input  wire logic          re,    // Read strobe
	input  wire logic [AW-1:0] raddr, // Read address
	output logic      [DW-1:0] rdata  // Read word, one cycle after re
);
	logic [DW-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		if (re) begin
			rdata <= mem[raddr];
		end
	end
endmodule // dcwf_ram
`default_nettype wire

//--- rtl/dcwf_core.sv
// Dual-clock 1024 x 36 FIFO with APB resource registers, mailbox and rewind.
// Assumes pclk runs at least four times faster than either port clock.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`default_nettype none
module dcwf_core
	import dcwf_pkg::*;
(
	input  wire logic          pclk,                 // Core clock
	input  wire logic          presetn,              // Async reset, active low
	input  wire logic [7:0]    paddr,                // APB address
	input  wire logic          psel,                 // APB select
	input  wire logic          penable,              // APB enable
	input  wire logic          pwrite,               // APB direction
	input  wire logic [31:0]   pwdata,               // APB write data
	output logic      [31:0]   prdata,               // APB read data
	output logic               pready,               // APB ready
	output logic               pslverr,              // APB error on unmapped
	input  wire logic          master_clear_n,       // Master clear, active low
	input  wire logic          input_port_clock,     // Write port clock pin
	input  wire logic          output_port_clock,    // Read port clock pin
	input  wire logic          wr_enable_a,          // Write enable one
	input  wire logic          wr_enable_b,          // Write enable two
	input  wire logic [2:0]    wr_side_addr,         // Input port address
	input  wire logic [1:0]    wr_width_sel,         // Input port width
	input  wire logic [DW-1:0] d_in,                 // Input data bus
	input  wire logic          rd_enable_a,          // Read enable one
	input  wire logic          rd_enable_b,          // Read enable two
	input  wire logic [2:0]    rd_side_addr,         // Output port address
	input  wire logic [1:0]    rd_width_sel,         // Output port width
	input  wire logic [1:0]    rewind_mode_ctl,      // Rewind mode
	input  wire logic          rewind_trigger,       // Rewind strobe
	input  wire logic          passthrough_enable_n, // Bypass, active low
	input  wire logic          cmd_source_select,    // Load source port
	input  wire logic          out_drive_enable_n,   // Output drive, active low
	input  wire logic [15:0]   q_in,                 // Output bus low bits in
	output logic      [DW-1:0] q_out,                // Output data bus
	output logic               q_oe_n,               // Output bus enable, low drives
	output logic               fifo_full_flag,       // Full
	output logic               near_full_flag,       // Almost full
	output logic               half_level_flag,      // Half full
	output logic               mbox_full_ind,        // Mailbox full
	output logic               fifo_empty_ind,       // Empty
	output logic               near_empty_flag,      // Almost empty
	output logic               parity_err_ind,       // Parity error
	output logic               mbox_empty_ind        // Mailbox empty
);
	// ==============================================
	// Reset and pin synchronisers
	logic rst_n;
	assign rst_n = presetn & master_clear_n;

	logic          ws_clk, ws_ena, ws_enb;
	logic [2:0]    ws_addr;
	logic [1:0]    ws_wid;
	logic [DW-1:0] ws_d;
	logic          rs_clk, rs_ena, rs_enb, rs_rt, rs_oen, rs_csel;
	logic [2:0]    rs_addr;
	logic [1:0]    rs_wid, rs_rtm;
	logic [15:0]   rs_q;

	dcwf_sync #(.W(44)) u_wsync (
		.clk   (pclk),
		.rst_n (rst_n),
		.din   ({input_port_clock, wr_enable_a, wr_enable_b, wr_side_addr, wr_width_sel, d_in}),
		.dout  ({ws_clk, ws_ena, ws_enb, ws_addr, ws_wid, ws_d})
	);
	dcwf_sync #(.W(29)) u_rsync (
		.clk   (pclk),
		.rst_n (rst_n),
		.din   ({output_port_clock, rd_enable_a, rd_enable_b, rd_side_addr, rd_width_sel,
		         rewind_mode_ctl, rewind_trigger, out_drive_enable_n, cmd_source_select, q_in}),
		.dout  ({rs_clk, rs_ena, rs_enb, rs_addr, rs_wid, rs_rtm, rs_rt, rs_oen, rs_csel, rs_q})
	);

	// Each port steps only on its own clock edge
	logic wclk_q, rclk_q, wr_tick, rd_tick;
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			wclk_q <= 1'b0;
			rclk_q <= 1'b0;
		end else begin
			wclk_q <= ws_clk;
			rclk_q <= rs_clk;
		end
	end
	assign wr_tick = ws_clk & ~wclk_q;
	assign rd_tick = rs_clk & ~rclk_q;

	// ==============================================
	// Resource registers
	logic [CTRL_W-1:0] ctrl_r;
	logic [AW-1:0]     af_off_r, ae_off_r, rwofs_r;
	logic              apb_hit, apb_wr, ld_go;
	logic [2:0]        ld_addr;
	logic [15:0]       ld_data;
	logic [31:0]       apb_view;

	assign apb_wr  = psel & penable & pwrite & apb_hit;
	assign ld_go   = rs_csel ? rd_tick : wr_tick;
	assign ld_addr = rs_csel ? rs_addr : ws_addr;
	assign ld_data = rs_csel ? rs_q : ws_d[15:0];

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r   <= CTRL_RST;
			af_off_r <= NEAR_DEF;
			ae_off_r <= NEAR_DEF;
			rwofs_r  <= RWOFS_RST;
		end else if (apb_wr) begin
			case (paddr)
				OFS_CTRL:   ctrl_r   <= pwdata[CTRL_W-1:0];
				OFS_AFULL:  af_off_r <= pwdata[AW-1:0];
				OFS_AEMPTY: ae_off_r <= pwdata[AW-1:0];
				OFS_RWOFS:  rwofs_r  <= pwdata[AW-1:0];
				default:    ;
			endcase
		end else if (ld_go) begin
			case (ld_addr)
				PA_CTRL:   ctrl_r   <= ld_data[CTRL_W-1:0];
				PA_AFULL:  af_off_r <= ld_data[AW-1:0];
				PA_AEMPTY: ae_off_r <= ld_data[AW-1:0];
				PA_RWOFS:  rwofs_r  <= ld_data[AW-1:0];
				default:   ;
			endcase
		end
	end

	// ==============================================
	// Pointers and Gray crossing
	function automatic logic [AW:0] g2b(input logic [AW:0] g);
		logic [AW:0] b;
		b[AW] = g[AW];
		for (int i = AW - 1; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	logic [AW:0] wptr_r, rptr_r, wptr_nxt, rptr_nxt, wgray_r, rgray_r, wgray_s, rgray_s;
	logic [AW:0] rptr_w, wptr_rd, wcount, rcount, wcnt_nxt, rcnt_nxt, mark_r;

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			wgray_r <= '0;
			rgray_r <= '0;
		end else begin
			wgray_r <= wptr_nxt ^ (wptr_nxt >> 1);
			rgray_r <= rptr_nxt ^ (rptr_nxt >> 1);
		end
	end
	dcwf_sync #(.W(AW + 1)) u_wg_sync (
		.clk   (pclk),
		.rst_n (rst_n),
		.din   (wgray_r),
		.dout  (wgray_s)
	);
	dcwf_sync #(.W(AW + 1)) u_rg_sync (
		.clk   (pclk),
		.rst_n (rst_n),
		.din   (rgray_r),
		.dout  (rgray_s)
	);
	assign rptr_w   = g2b(rgray_s);
	assign wptr_rd  = g2b(wgray_s);
	assign wcount   = wptr_r - rptr_w;
	assign rcount   = wptr_rd - rptr_r;
	assign wcnt_nxt = wptr_nxt - rptr_w;
	assign rcnt_nxt = wptr_rd - rptr_nxt;

	// ==============================================
	// Write side: width assembly, reversal, parity generation
	logic [1:0]    wr_chunk_r;
	logic [DW-1:0] wr_asm_r, asm_word, wr_word, ram_q;
	logic          wr_go, wr_last, wr_commit, rd_fetch;
	logic [3:0]    par_bad;

	assign wr_go = wr_tick & ws_ena & ws_enb;

	always_comb begin
		asm_word = wr_asm_r;
		wr_last  = 1'b1;
		unique case (ws_wid)
			W36: asm_word = ws_d;
			W18: begin
				asm_word[18*wr_chunk_r[0] +: 18] = ws_d[17:0];
				wr_last = wr_chunk_r[0];
			end
			W9: begin
				asm_word[9*wr_chunk_r +: 9] = ws_d[8:0];
				wr_last = &wr_chunk_r;
			end
			default: asm_word = ws_d;
		endcase
	end

	for (genvar b = 0; b < 4; b++) begin : g_byte
		logic [8:0] src;
		assign src = ctrl_r[CB_BREV] ? asm_word[9*(3-b) +: 9] : asm_word[9*b +: 9];
		assign wr_word[9*b +: 9] = ctrl_r[CB_PGEN] ?
			{^src[7:0] ^ ~ctrl_r[CB_EVEN], src[7:0]} : src;
		assign par_bad[b] = (^ram_q[9*b +: 9]) == ctrl_r[CB_EVEN];
	end

	assign wr_commit = wr_go & wr_last & (wcount != FULL_LVL);
	assign wptr_nxt  = wptr_r + {{AW{1'b0}}, wr_commit};

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_chunk_r <= 2'b00;
			wr_asm_r   <= '0;
			wptr_r     <= '0;
		end else begin
			wptr_r <= wptr_nxt;
			if (wr_go) begin
				wr_asm_r   <= asm_word;
				wr_chunk_r <= wr_last ? 2'b00 : wr_chunk_r + 2'b01;
			end
		end
	end

	dcwf_ram u_ram (
		.clk   (pclk),
		.we    (wr_commit),
		.waddr (wptr_r[AW-1:0]),
		.wdata (wr_word),
		.re    (rd_fetch),
		.raddr (rptr_r[AW-1:0]),
		.rdata (ram_q)
	);

	// ==============================================
	// Read side: fetch, width split, rewind
	logic       rd_go, rd_more, rd_last, rd_load_q, oe_hold, rewind_go;
	logic [1:0] rd_chunk_r;

	assign oe_hold   = ctrl_r[CB_OEHOLD] & rs_oen;
	assign rewind_go = rd_tick & rs_rt;
	assign rd_go     = rd_tick & rs_ena & rs_enb & ~oe_hold & ~rs_rt;
	assign rd_fetch  = rd_go & (rd_chunk_r == 2'b00) & (rcount != '0);
	assign rd_more   = rd_go & (rd_chunk_r != 2'b00);

	always_comb begin
		unique case (rs_wid)
			W18:     rd_last = rd_chunk_r[0];
			W9:      rd_last = &rd_chunk_r;
			default: rd_last = 1'b1;
		endcase
	end

	always_comb begin
		rptr_nxt = rptr_r + {{AW{1'b0}}, rd_fetch};
		if (rewind_go) begin
			unique case (rs_rtm)
				RW_SETMARK: rptr_nxt = rptr_r;
				RW_TOMARK:  rptr_nxt = mark_r;
				RW_MARKOFS: rptr_nxt = mark_r + {1'b0, rwofs_r};
				RW_SKIP:    rptr_nxt = rptr_r + {1'b0, rwofs_r};
			endcase
		end
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			rptr_r     <= '0;
			mark_r     <= '0;
			rd_chunk_r <= 2'b00;
			rd_load_q  <= 1'b0;
		end else begin
			rptr_r    <= rptr_nxt;
			rd_load_q <= rd_fetch;
			if (rewind_go && rs_rtm == RW_SETMARK) begin
				mark_r <= rptr_r;
			end
			if (rd_fetch || rd_more) begin
				rd_chunk_r <= rd_last ? 2'b00 : rd_chunk_r + 2'b01;
			end
		end
	end

	// ==============================================
	// Mailbox with toggle handshake
	logic [DW-1:0] mbox_r;
	logic          mb_wtog_r, mb_rtog_r, mb_wtog_s, mb_rtog_s, mbox_wr, mbox_rd;

	assign mbox_wr = wr_tick & (ws_addr == PA_MBOX) & ~mbox_full_ind;
	assign mbox_rd = rd_tick & (rs_addr == PA_MBOX) & ~mbox_empty_ind;

	dcwf_sync #(.W(2)) u_mb_sync (
		.clk   (pclk),
		.rst_n (rst_n),
		.din   ({mb_wtog_r, mb_rtog_r}),
		.dout  ({mb_wtog_s, mb_rtog_s})
	);

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			mbox_r         <= '0;
			mb_wtog_r      <= 1'b0;
			mb_rtog_r      <= 1'b0;
			mbox_full_ind  <= 1'b0;
			mbox_empty_ind <= 1'b1;
		end else begin
			if (mbox_wr) begin
				mbox_r    <= ws_d;
				mb_wtog_r <= ~mb_wtog_r;
			end
			if (mbox_rd) begin
				mb_rtog_r <= ~mb_rtog_r;
			end
			if (wr_tick) begin
				mbox_full_ind <= (mb_wtog_r ^ mbox_wr) != mb_rtog_s;
			end
			if (rd_tick) begin
				mbox_empty_ind <= (mb_rtog_r ^ mbox_rd) == mb_wtog_s;
			end
		end
	end

	// ==============================================
	// Output word register and bus
	function automatic logic [DW-1:0] port_slice(input logic [DW-1:0] w, input logic [1:0] c,
		input logic [1:0] wid);
		unique case (wid)
			W18:     return {18'h00000, w[18*c[0] +: 18]};
			W9:      return {27'h0000000, w[9*c +: 9]};
			default: return w;
		endcase
	endfunction

	logic [DW-1:0] out_word_r, q_out_r, reg_view;
	logic          reg_rd;

	always_comb begin
		reg_rd   = rd_tick & ~rs_csel;
		reg_view = '0;
		case (rs_addr)
			PA_CTRL:   reg_view = DW'(ctrl_r);
			PA_AFULL:  reg_view = DW'(af_off_r);
			PA_AEMPTY: reg_view = DW'(ae_off_r);
			PA_RWOFS:  reg_view = DW'(rwofs_r);
			default:   reg_rd = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			out_word_r     <= '0;
			q_out_r        <= '0;
			parity_err_ind <= 1'b0;
		end else if (rd_load_q) begin
			out_word_r     <= ram_q;
			q_out_r        <= port_slice(ram_q, 2'b00, rs_wid);
			parity_err_ind <= |par_bad;
		end else if (rd_more) begin
			q_out_r <= port_slice(out_word_r, rd_chunk_r, rs_wid);
		end else if (mbox_rd) begin
			q_out_r <= mbox_r;
		end else if (reg_rd) begin
			q_out_r <= reg_view;
		end
	end

	assign q_out  = passthrough_enable_n ? q_out_r : d_in;
	assign q_oe_n = out_drive_enable_n;

	// ==============================================
	// Status flags; pointer-only logic keeps paralleled units in step
	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			fifo_full_flag <= 1'b0;
			near_full_flag <= 1'b0;
		end else if (wr_tick) begin
			fifo_full_flag <= wcnt_nxt == FULL_LVL;
			near_full_flag <= wcnt_nxt >= (FULL_LVL - {1'b0, af_off_r});
		end
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			fifo_empty_ind  <= 1'b1;
			near_empty_flag <= 1'b1;
		end else if (rd_tick) begin
			fifo_empty_ind  <= rcnt_nxt == '0;
			near_empty_flag <= rcnt_nxt <= {1'b0, ae_off_r};
		end
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			half_level_flag <= 1'b0;
		end else if (ctrl_r[CB_HFSRC] ? rd_tick : wr_tick) begin
			half_level_flag <= (ctrl_r[CB_HFSRC] ? rcnt_nxt : wcnt_nxt) >= HALF_LVL;
		end
	end

	// ==============================================
	// APB slave, zero wait states
	always_comb begin
		apb_hit  = 1'b1;
		apb_view = 32'h00000000;
		case (paddr)
			OFS_CTRL:   apb_view = 32'(ctrl_r);
			OFS_AFULL:  apb_view = 32'(af_off_r);
			OFS_AEMPTY: apb_view = 32'(ae_off_r);
			OFS_RWOFS:  apb_view = 32'(rwofs_r);
			OFS_MBOX:   apb_view = mbox_r[31:0];
			OFS_STAT:   apb_view = 32'({parity_err_ind, mbox_empty_ind, mbox_full_ind,
				near_empty_flag, fifo_empty_ind, half_level_flag, near_full_flag, fifo_full_flag});
			OFS_MARK:   apb_view = 32'(mark_r);
			default:    apb_hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			prdata <= apb_view;
		end
	end
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~apb_hit;

	// ==============================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!rst_n);

	property p_full_drop;
		wcount == FULL_LVL |=> $stable(wptr_r);
	endproperty
	a_full_drop: assert property (p_full_drop) else $error("write taken while full");
	property p_wr_both;
		$changed(wptr_r) |-> $past(wr_tick && ws_ena && ws_enb);
	endproperty
	a_wr_both: assert property (p_wr_both) else $error("write without both enables");
	property p_rd_both;
		$changed(rptr_r) && !$past(rewind_go) |-> $past(rd_tick && rs_ena && rs_enb);
	endproperty
	a_rd_both: assert property (p_rd_both) else $error("read without both enables");
	property p_defaults;
		$rose(rst_n) |-> af_off_r == NEAR_DEF && ae_off_r == NEAR_DEF && fifo_empty_ind;
	endproperty
	a_defaults: assert property (p_defaults) else $error("bad defaults after clear");
	property p_parity;
		rd_fetch |-> ##2 parity_err_ind == $past(|par_bad);
	endproperty
	a_parity: assert property (p_parity) else $error("parity flag mismatch");
	property p_bypass;
		!passthrough_enable_n |-> q_out == d_in;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass not joined");
	property p_mbox;
		mbox_wr |=> mbox_full_ind && $stable(mb_rtog_r) [*1];
	endproperty
	a_mbox: assert property (p_mbox) else $error("mailbox full not set");
	property p_rewind;
		rewind_go && rs_rtm == RW_TOMARK |=> rptr_r == $past(mark_r);
	endproperty
	a_rewind: assert property (p_rewind) else $error("rewind missed mark");
	property p_oe_hold;
		oe_hold && !rewind_go |=> $stable(rptr_r);
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("read advanced while held");
	property p_part_word;
		wr_go && !wr_last |=> $stable(wptr_r);
	endproperty
	a_part_word: assert property (p_part_word) else $error("partial word committed");
endmodule // dcwf_core
`default_nettype wire

//--- tb/dcwf_port_model.sv
// Producer and consumer logic on the two ports of the FIFO.
// Assumes pclk at 250 MHz; port clocks run free, slower than pclk/4.
`default_nettype none
module dcwf_port_model
	import dcwf_pkg::*;
(
	input  wire logic          pclk,              // Core clock
	input  wire logic [DW-1:0] q_out,             // Output data bus
	output logic               input_port_clock,  // Write port clock
	output logic               output_port_clock, // Read port clock
	output logic               wr_enable_a,       // Write enable one
	output logic               wr_enable_b,       // Write enable two
	output logic [2:0]         wr_side_addr,      // Input port address
	output logic [DW-1:0]      d_in,              // Input data bus
	output logic               rd_enable_a,       // Read enable one
	output logic               rd_enable_b,       // Read enable two
	output logic [2:0]         rd_side_addr       // Output port address
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==============================================
	// Free-running port clocks, unrelated in phase
	initial begin
		input_port_clock = 1'b0;
		#40;
		forever #16 input_port_clock = ~input_port_clock;
	end
	initial begin
		output_port_clock = 1'b0;
		#45;
		forever #24 output_port_clock = ~output_port_clock;
	end
	initial begin
		{wr_enable_a, wr_enable_b, rd_enable_a, rd_enable_b} = 4'h0;
		{wr_side_addr, rd_side_addr} = 6'h00;
		d_in = 36'h0_0000_0000;
	end
	// ==============================================
	// One transfer per port cycle, held across the rising edge
	task automatic put(input logic [DW-1:0] w, input logic [2:0] a, input logic eb);
		@(negedge input_port_clock);
		@(posedge pclk);
		wr_enable_a  <= (a == 3'h0);
		wr_enable_b  <= eb;
		wr_side_addr <= a;
		d_in         <= w;
		@(negedge input_port_clock);
		@(posedge pclk);
		{wr_enable_a, wr_enable_b, wr_side_addr} <= 5'h00;
		d_in <= ~w; // Released bus shows no stale word
	endtask
	task automatic get(output logic [DW-1:0] w, input logic [2:0] a);
		@(negedge output_port_clock);
		@(posedge pclk);
		{rd_enable_a, rd_enable_b} <= 2'h3;
		rd_side_addr <= a;
		@(negedge output_port_clock);
		@(posedge pclk);
		{rd_enable_a, rd_enable_b, rd_side_addr} <= 5'h00;
		w = q_out;
	endtask
endmodule // dcwf_port_model
`default_nettype wire

//--- tb/tb_dual_clock_wide_fifo.sv
// Self-checking bench for the dual-clock wide FIFO.
// Assumes the port model drives both port sides.
`default_nettype none
module tb_dual_clock_wide_fifo
	import dcwf_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic mclr_n, pass_n, odrv_n, wea, web, rea, reb, ipc, opc, q_oe_n;
	logic ff, nf, hf, mf, ef, ne, pe, me;
	logic [2:0] wsa, rsa;
	logic [1:0] rws;
	logic [DW-1:0] d_in, q_out, q;
	int failures = 0;
	int comparisons = 0;
	logic [6:0]    cfg [4] = '{7'h00, 7'h04, 7'h01, 7'h03};
	logic [DW-1:0] dws [4] = '{36'h0, 36'h1, 36'h0, 36'hF_FFFF_FFFF};
	logic [DW-1:0] dex [4] = '{36'h0, 36'h0_0800_0000, 36'h8_0402_0100, 36'h7_FBFD_FEFF};
	logic          pex [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
	dcwf_core u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .master_clear_n(mclr_n),
		.input_port_clock(ipc), .output_port_clock(opc), .wr_enable_a(wea),
		.wr_enable_b(web), .wr_side_addr(wsa), .wr_width_sel(W36), .d_in(d_in),
		.rd_enable_a(rea), .rd_enable_b(reb), .rd_side_addr(rsa), .rd_width_sel(rws),
		.rewind_mode_ctl(2'h0), .rewind_trigger(1'b0), .passthrough_enable_n(pass_n),
		.cmd_source_select(1'b0), .out_drive_enable_n(odrv_n), .q_in(16'h0000),
		.q_out(q_out), .q_oe_n(q_oe_n), .fifo_full_flag(ff), .near_full_flag(nf),
		.half_level_flag(hf), .mbox_full_ind(mf), .fifo_empty_ind(ef),
		.near_empty_flag(ne), .parity_err_ind(pe), .mbox_empty_ind(me));
	dcwf_port_model u_port (.pclk(pclk), .q_out(q_out), .input_port_clock(ipc),
		.output_port_clock(opc), .wr_enable_a(wea), .wr_enable_b(web),
		.wr_side_addr(wsa), .d_in(d_in), .rd_enable_a(rea), .rd_enable_b(reb),
		.rd_side_addr(rsa));
	// ==============================================
	// Bus cycles, comparison and verdict
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n == 50) failures++;
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (failures == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ==============================================
	// Clock, watchdog and tests
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		#200000;
		failures++;
		print_verdict();
	end
	initial begin
		int i;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{presetn, mclr_n, pass_n, odrv_n} = 4'b0110;
		rws = W36;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		chk({ef, ne, ff, nf, me, mf}, 6'b110010);
		apb(OFS_AFULL, 1'b0, 32'h0);
		chk(rd, 32'h8);
		apb(8'h1C, 1'b0, 32'h0);
		chk(err, 1'b1);
		u_port.put(36'h1_2345_6789, 3'h0, 1'b0);
		for (i = 0; i < 3; i++) u_port.put(36'h5_0000_0000 + i, 3'h0, 1'b1);
		for (i = 0; i < 3; i++) begin
			u_port.get(q, 3'h0);
			chk(q, 36'h5_0000_0000 + i);
		end
		chk(ef, 1'b1);
		u_port.get(q, 3'h0);
		chk(q, 36'h5_0000_0002);
		for (i = 0; i < 4; i++) begin
			apb(OFS_CTRL, 1'b1, {25'h0, cfg[i]});
			u_port.put(dws[i], 3'h0, 1'b1);
			u_port.get(q, 3'h0);
			chk(q, dex[i]);
			chk(pe, pex[i]);
		end
		apb(OFS_AEMPTY, 1'b1, 32'h1);
		repeat (2) u_port.put(36'h0_0000_0001, 3'h0, 1'b1);
		repeat (30) @(posedge pclk);
		chk(ne, 1'b0);
		mclr_n <= 1'b0;
		@(posedge pclk);
		@(posedge pclk);
		chk({ef, ne}, 2'b11);
		mclr_n <= 1'b1;
		apb(OFS_AEMPTY, 1'b0, 32'h0);
		chk(rd, 32'h8);
		u_port.put(36'h0_ABCD_1234, 3'h1, 1'b1);
		repeat (30) @(posedge pclk);
		chk({mf, me, ef}, 3'b101);
		apb(OFS_MBOX, 1'b0, 32'h0);
		chk(rd, 32'hABCD_1234);
		u_port.get(q, 3'h1);
		chk(q, 36'h0_ABCD_1234);
		repeat (30) @(posedge pclk);
		chk(me, 1'b1);
		rws <= W18;
		u_port.put(36'hA_BCDE_F012, 3'h0, 1'b1);
		repeat (30) @(posedge pclk);
		u_port.get(q, 3'h0);
		chk(q, 36'hA_BCDE_F012 & 36'h0_0003_FFFF);
		u_port.get(q, 3'h0);
		chk(q, 36'hA_BCDE_F012 >> 18);
		{pass_n, odrv_n} <= 2'b01;
		@(posedge pclk);
		@(negedge pclk);
		chk(q_out, d_in);
		chk(q_oe_n, 1'b1);
		{pass_n, odrv_n} <= 2'b10;
		print_verdict();
	end
endmodule // tb_dual_clock_wide_fifo
`default_nettype wire
